// *** common/tile_regs_pkg.sv ***
// Shared constants and carriers of the tile status and control register bank
package tile_regs_pkg;

    // ------------------------------------------------------------
    // Register numbers and resource identifiers
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_TILE_CONTROL  = 8'h02;
    localparam logic [7:0]  REG_BOOT_STATUS   = 8'h03;
    localparam logic [7:0]  REG_SECURITY      = 8'h05;
    localparam logic [7:0]  REG_RO_CONTROL    = 8'h06;
    localparam logic [7:0]  REG_RO_VALUE0     = 8'h07;
    localparam int          RO_COUNT          = 4;
    localparam int          RID_SHIFT         = 8;
    localparam logic [7:0]  RID_TYPE_PS       = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CTL_DLY_LSB       = 18;
    localparam int          CTL_DLY_MSB       = 25;
    localparam int          CTL_DIV_LSB       = 9;
    localparam int          CTL_DIV_MSB       = 17;
    localparam int          CTL_RGMII_EN      = 8;
    localparam int          CTL_LP_DYN        = 5;
    localparam int          CTL_LP_EN         = 4;
    localparam int          CTL_UTMI          = 2;
    localparam int          CTL_ULPI_HW       = 1;
    localparam int          SEC_WR_DIS        = 31;
    localparam int          SEC_GDBG_DIS      = 14;
    localparam int          SEC_OTP_LOCK_ALL  = 12;
    localparam int          SEC_OTP_LOCK_LSB  = 8;
    localparam int          SEC_OTP_RED       = 7;
    localparam int          SEC_OTP_BOOT      = 5;
    localparam int          SEC_JTAG_CFG_DIS  = 4;
    localparam int          SEC_TAP_DIS       = 0;
    localparam int          ROC_CORE          = 1;
    localparam int          ROC_PERIPH        = 0;

    // Writable bits; all others are reserved and read as zero
    localparam logic [31:0] CTL_WR_MASK       = 32'h03ff_ff36;
    localparam logic [31:0] SEC_WR_MASK       = 32'h8000_5fb1;
    localparam logic [1:0]  ROC_WR_MASK       = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTL_RST           = 32'h0000_0000;
    localparam logic [31:0] SEC_RST           = 32'h0000_0000;
    localparam logic [1:0]  ROC_RST           = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] rid;
        logic [31:0] wdata;
    } ps_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } ps_rsp_t;

    typedef struct packed {
        logic [7:0]  proc_num;
        logic        mode_override;
        logic        core1_off;
        logic        skip_otp_poll;
        logic        from_ram;
        logic        from_jtag;
        logic [1:0]  pll_mode;
    } boot_pins_t;

    typedef struct packed {
        logic        global_debug_block;
        logic        otp_lock_all;
        logic [3:0]  otp_lock;
        logic        otp_redundancy;
        logic        boot_from_otp;
        logic        jtag_cfg_block;
        logic        jtag_tap_block;
    } sec_ctl_t;

endpackage

// *** verilog/tile_status_control_regs.sv ***
// Processor status register bank of one tile with clock and oscillator logic
//
// Overview of operation
// RQ1 - Transmit data delayed by field cycles
// RQ2 - Transmit clock toggles at divider compare points
// RQ3 - Software programs divider as ratio minus one
// RQ4 - Bit eight enables the RGMII ports
// RQ5 - Dynamic divider acts only when threads paused
// RQ6 - Bit four enables low-power clock divider
// RQ7 - Bit two selects UTMI, else ULPI
// RQ8 - Bit one enables ULPI hardware support
// RQ9 - Boot status read-only, shows processor number
// RQ10 - Boot status shows mode pins and sources
// RQ11 - Boot status shows core1 off, skip poll
// RQ12 - Write-disable bit locks security register
// RQ13 - Security bits lock all or single sectors
// RQ14 - Security bits block global debug, TAP
// RQ15 - Security bits: redundancy, OTP boot, JTAG block
// RQ16 - Security register loaded from OTP word
// RQ17 - Four oscillators with counters, software started
// RQ18 - Read counters ten cycles after stopping
// RQ19 - Control bits enable core, peripheral oscillators
// RQ20 - Oscillators asynchronous, counts give random bits
// RQ21 - Sixteen-bit counters survive system reset
// RQ22 - Resource identifier is number shifted, ORed
// RQ23 - Reserved bits zero, locked writes ignored
`timescale 1ns/100ps

module tile_status_control_regs
    import tile_regs_pkg::*;
#(
    parameter int TXD_W    = 5,
    parameter int DLY_LEN  = 256,
    parameter int LP_DIV   = 4,
    parameter int RO_W     = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire ps_req_t          ps_req,
    output ps_rsp_t               ps_rsp,
    input  wire boot_pins_t       boot_pins,
    input  wire logic             otp_load,
    input  wire logic [31:0]      otp_sec_word,
    input  wire logic             all_threads_paused,
    input  wire logic [TXD_W-1:0] tx_data_i,
    output logic [TXD_W-1:0]      tx_data_o,
    output logic                  tx_clk_o,
    output logic                  rgmii_en_o,
    output logic                  lp_div_active_o,
    output logic                  core_clk_en_o,
    output logic                  utmi_sel_o,
    output logic                  ulpi_hw_en_o,
    output sec_ctl_t              sec_ctl_o,
    output logic                  ro_en_core_o,
    output logic                  ro_en_periph_o,
    input  wire logic [3:0]       ro_tick
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                       ctl;
        logic [31:0]                       sec;
        logic [1:0]                        roc;
        logic [RO_COUNT-1:0][RO_W-1:0]     ro_cnt;
        logic [8:0]                        div_cnt;
        logic                              tx_clk;
        logic [DLY_LEN-1:0][TXD_W-1:0]     dly_line;
        logic [TXD_W-1:0]                  tx_data;
        logic [7:0]                        lp_cnt;
        logic                              core_clk_en;
        ps_rsp_t                           rsp;
    } state_t;

    // Ring counters have no reset, so their start value comes from here
    state_t st_r = '0;
    state_t st_nxt;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic is_ps_rid(input logic [15:0] rid);
        return rid[7:0] == RID_TYPE_PS;                           // RQ22
    endfunction

    function automatic logic [7:0] reg_num(input logic [15:0] rid);
        return rid[15:RID_SHIFT];                                 // RQ22
    endfunction

    function automatic logic mapped(input logic [15:0] rid);
        logic [7:0] n;
        n = reg_num(rid);
        return is_ps_rid(rid) &&
               (n == REG_TILE_CONTROL || n == REG_BOOT_STATUS ||
                n == REG_SECURITY || n == REG_RO_CONTROL ||
                (n >= REG_RO_VALUE0 &&
                 n < REG_RO_VALUE0 + 8'(RO_COUNT)));
    endfunction

    wire logic [7:0] dly_val  = st_r.ctl[CTL_DLY_MSB:CTL_DLY_LSB];
    wire logic [8:0] div_val  = st_r.ctl[CTL_DIV_MSB:CTL_DIV_LSB];
    wire logic       lp_act   = st_r.ctl[CTL_LP_EN] &&
                                (!st_r.ctl[CTL_LP_DYN] ||
                                 all_threads_paused);             // RQ5 RQ6

    function automatic logic [31:0] read_word(input logic [7:0] n,
                                              input state_t s);
        logic [31:0] w;
        logic [7:0]  idx;
        w   = 32'h0000_0000;
        idx = n - REG_RO_VALUE0;
        case (n)
            REG_TILE_CONTROL: w = s.ctl & CTL_WR_MASK;            // RQ23
            REG_BOOT_STATUS: begin
                w[23:16] = boot_pins.proc_num;                    // RQ9
                w[8]     = boot_pins.mode_override;               // RQ10
                w[5]     = boot_pins.core1_off;                   // RQ11
                w[4]     = boot_pins.skip_otp_poll;               // RQ11
                w[3]     = boot_pins.from_ram;                    // RQ10
                w[2]     = boot_pins.from_jtag;                   // RQ10
                w[1:0]   = boot_pins.pll_mode;                    // RQ10
            end
            REG_SECURITY:     w = s.sec & SEC_WR_MASK;            // RQ23
            REG_RO_CONTROL:   w[1:0] = s.roc;
            default: begin
                if (n >= REG_RO_VALUE0 &&
                    n < REG_RO_VALUE0 + 8'(RO_COUNT)) begin
                    w[RO_W-1:0] = s.ro_cnt[idx[1:0]];             // RQ21
                end
            end
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       wr;
        logic [7:0] n;
        wr     = ps_req.valid && ps_req.write && mapped(ps_req.rid);
        n      = reg_num(ps_req.rid);
        st_nxt = st_r;

        // Register access; the boot status word has no write path
        st_nxt.rsp.ack   = ps_req.valid;
        st_nxt.rsp.err   = ps_req.valid && !mapped(ps_req.rid);
        st_nxt.rsp.rdata = 32'h0000_0000;
        if (ps_req.valid && !ps_req.write && mapped(ps_req.rid)) begin
            st_nxt.rsp.rdata = read_word(n, st_r);                // RQ9
        end
        if (wr && n == REG_TILE_CONTROL) begin
            st_nxt.ctl = ps_req.wdata & CTL_WR_MASK;              // RQ4 RQ7 RQ8
        end
        if (wr && n == REG_RO_CONTROL) begin
            st_nxt.roc = ps_req.wdata[1:0] & ROC_WR_MASK;         // RQ19
        end
        // Once write-disable is set only a reset or an OTP load with bit 31 clear reopens the register
        if (wr && n == REG_SECURITY && !st_r.sec[SEC_WR_DIS]) begin
            st_nxt.sec = ps_req.wdata & SEC_WR_MASK;              // RQ12 RQ23
        end
        // The OTP copy is hardware and wins over a software write
        if (otp_load) begin
            st_nxt.sec = otp_sec_word & SEC_WR_MASK;              // RQ16
        end

        // Ring oscillator counters; ticks arrive from the free oscillators
        for (int i = 0; i < RO_COUNT; i++) begin
            if (ro_tick[i] &&
                st_r.roc[(i < 2) ? ROC_CORE : ROC_PERIPH]) begin  // RQ17 RQ20
                st_nxt.ro_cnt[i] = st_r.ro_cnt[i] + RO_W'(1);
            end
        end

        // Transmit clock divider
        if (st_r.div_cnt >= div_val) begin
            st_nxt.div_cnt = 9'h000;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + 9'h001;
        end
        if (st_r.div_cnt == div_val) begin
            st_nxt.tx_clk = 1'b1;                                 // RQ2
        end else if (st_r.div_cnt == (div_val >> 1)) begin
            st_nxt.tx_clk = 1'b0;                                 // RQ2
        end

        // Transmit data delay line
        st_nxt.dly_line = {st_r.dly_line[DLY_LEN-2:0], tx_data_i};
        if (dly_val == 8'h00) begin
            st_nxt.tx_data = tx_data_i;                           // RQ1
        end else begin
            st_nxt.tx_data = st_r.dly_line[dly_val - 8'h01];      // RQ1
        end

        // Low-power divider: a core clock enable every LP_DIV cycles
        if (lp_act) begin
            if (st_r.lp_cnt >= 8'(LP_DIV - 1)) begin
                st_nxt.lp_cnt      = 8'h00;
                st_nxt.core_clk_en = 1'b1;                        // RQ5 RQ6
            end else begin
                st_nxt.lp_cnt      = st_r.lp_cnt + 8'h01;
                st_nxt.core_clk_en = 1'b0;
            end
        end else begin
            st_nxt.lp_cnt      = 8'h00;
            st_nxt.core_clk_en = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Counters stay across reset so that entropy gathered is not lost
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r             <= '0;
            st_r.ctl         <= CTL_RST;
            st_r.sec         <= SEC_RST;
            st_r.roc         <= ROC_RST;
            st_r.core_clk_en <= 1'b1;
            st_r.ro_cnt      <= st_r.ro_cnt;                      // RQ21
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ps_rsp          = st_r.rsp;
    assign tx_data_o       = st_r.tx_data;
    assign tx_clk_o        = st_r.tx_clk;
    assign rgmii_en_o      = st_r.ctl[CTL_RGMII_EN];              // RQ4
    assign lp_div_active_o = lp_act;
    assign core_clk_en_o   = st_r.core_clk_en;
    assign utmi_sel_o      = st_r.ctl[CTL_UTMI];                  // RQ7
    assign ulpi_hw_en_o    = st_r.ctl[CTL_ULPI_HW];               // RQ8
    assign ro_en_core_o    = st_r.roc[ROC_CORE];                  // RQ19
    assign ro_en_periph_o  = st_r.roc[ROC_PERIPH];                // RQ19
    assign sec_ctl_o.global_debug_block = st_r.sec[SEC_GDBG_DIS]; // RQ14
    assign sec_ctl_o.otp_lock_all   = st_r.sec[SEC_OTP_LOCK_ALL]; // RQ13
    assign sec_ctl_o.otp_lock       =
        st_r.sec[SEC_OTP_LOCK_LSB+3:SEC_OTP_LOCK_LSB];            // RQ13
    assign sec_ctl_o.otp_redundancy = st_r.sec[SEC_OTP_RED];      // RQ15
    assign sec_ctl_o.boot_from_otp  = st_r.sec[SEC_OTP_BOOT];     // RQ15
    assign sec_ctl_o.jtag_cfg_block = st_r.sec[SEC_JTAG_CFG_DIS]; // RQ15
    assign sec_ctl_o.jtag_tap_block = st_r.sec[SEC_TAP_DIS];      // RQ14

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire logic wr_ctl = ps_req.valid && ps_req.write &&
                        ps_req.rid == {REG_TILE_CONTROL, RID_TYPE_PS};
    wire logic wr_sec = ps_req.valid && ps_req.write &&
                        ps_req.rid == {REG_SECURITY, RID_TYPE_PS};
    wire logic rd_boot = ps_req.valid && !ps_req.write &&
                         ps_req.rid == {REG_BOOT_STATUS, RID_TYPE_PS};
    wire logic rd_roc = ps_req.valid && !ps_req.write &&
                        ps_req.rid == {REG_RO_CONTROL, RID_TYPE_PS};

    AST_TXCLK_HIGH: assert property (@(posedge clk) disable iff (srst) // RQ2
        ce && st_r.div_cnt == div_val |=> tx_clk_o)
        else $error("tx clock not high at divider value");
    AST_TXCLK_LOW: assert property (@(posedge clk) disable iff (srst) // RQ2
        ce && st_r.div_cnt == (div_val >> 1) && st_r.div_cnt != div_val
        |=> !tx_clk_o)
        else $error("tx clock not low at half divider value");
    AST_TXD_DELAY: assert property (@(posedge clk) disable iff (srst) // RQ1
        (ce && dly_val == 8'h02)[*3] |=> tx_data_o == $past(tx_data_i, 3))
        else $error("tx data delay wrong");
    AST_RGMII_EN: assert property (@(posedge clk) disable iff (srst) // RQ4
        ce && wr_ctl |=> rgmii_en_o == $past(ps_req.wdata[CTL_RGMII_EN]))
        else $error("rgmii enable not taken from write");
    AST_LP_STATIC: assert property (@(posedge clk) disable iff (srst) // RQ6
        st_r.ctl[CTL_LP_EN] && !st_r.ctl[CTL_LP_DYN] |-> lp_div_active_o)
        else $error("static divider not active");
    AST_LP_DYN_IDLE: assert property (@(posedge clk) disable iff (srst) // RQ5
        st_r.ctl[CTL_LP_DYN] && !all_threads_paused |-> !lp_div_active_o)
        else $error("dynamic divider active while threads run");
    AST_SEC_LOCK: assert property (@(posedge clk) disable iff (srst) // RQ12
        ce && st_r.sec[SEC_WR_DIS] && wr_sec && !otp_load
        |=> $stable(st_r.sec))
        else $error("locked security register changed");
    AST_BOOT_READ: assert property (@(posedge clk) disable iff (srst) // RQ9
        ce && rd_boot |=> ps_rsp.ack && !ps_rsp.err &&
        ps_rsp.rdata[23:16] == $past(boot_pins.proc_num) &&
        ps_rsp.rdata[1:0] == $past(boot_pins.pll_mode))
        else $error("boot status read wrong");
    AST_RO_HOLD: assert property (@(posedge clk) disable iff (srst) // RQ19
        ce && st_r.roc == 2'h0 |=> $stable(st_r.ro_cnt))
        else $error("stopped oscillator counter moved");
    AST_RESV_ZERO: assert property (@(posedge clk) disable iff (srst) // RQ23
        ce && rd_roc |=> ps_rsp.rdata[31:2] == 30'h0000_0000)
        else $error("reserved bits not zero");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (srst) // RQ22
        ce && ps_req.valid && !is_ps_rid(ps_req.rid) |=> ps_rsp.err)
        else $error("bad resource id not refused");

    COV_SEC_LOCKED_WRITE: cover property (@(posedge clk) disable iff (srst)
        ce && st_r.sec[SEC_WR_DIS] && wr_sec);
    COV_LP_DYNAMIC: cover property (@(posedge clk) disable iff (srst)
        st_r.ctl[CTL_LP_DYN] && lp_div_active_o);
    COV_RO_COUNT: cover property (@(posedge clk) disable iff (srst)
        ce && ro_tick[0] && ro_en_core_o);
    COV_TXCLK_RISE: cover property (@(posedge clk) disable iff (srst)
        $rose(tx_clk_o));

endmodule

// *** verif/core_model.sv ***
// Processor core model issuing status register reads and writes
`timescale 1ns/100ps

module core_model
    import tile_regs_pkg::*;
(
    input  wire logic    clk,
    output ps_req_t      ps_req,
    input  wire ps_rsp_t ps_rsp
);
    initial ps_req = '0;

    // ------------------------------------------------------------
    // One word access; released fields show inverted junk
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic [7:0] num,
                          input logic [7:0] kind, input logic [31:0] wd,
                          output logic [31:0] rd, output logic er,
                          output logic ok);
        int n;
        ok = 1'b0;
        rd = '0;
        er = 1'b0;
        @(posedge clk);
        ps_req <= '{1'b1, wr, {num, kind}, wd};
        @(posedge clk);
        ps_req <= '{1'b0, ~wr, ~{num, kind}, ~wd};
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge clk);
            if (ps_rsp.ack === 1'b1) begin
                ok = 1'b1;
                rd = ps_rsp.rdata;
                er = ps_rsp.err;
            end
        end
    endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench of the tile status and control register bank
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench;
    import tile_regs_pkg::*;
    logic         clk, srst, ce, otp_load, all_threads_paused;
    ps_req_t      ps_req;
    ps_rsp_t      ps_rsp;
    boot_pins_t   boot_pins;
    logic [31:0]  otp_sec_word, rd, base [4];
    logic [4:0]   tx_data_i, tx_data_o;
    logic         tx_clk_o, rgmii_en_o, lp_div_active_o, core_clk_en_o;
    logic         utmi_sel_o, ulpi_hw_en_o, ro_en_core_o, ro_en_periph_o;
    sec_ctl_t     sec_ctl_o;
    logic [3:0]   ro_tick;
    int           err_total, checks_done, cyc;

    tile_status_control_regs dut (.clk(clk), .srst(srst), .ce(ce),
        .ps_req(ps_req), .ps_rsp(ps_rsp), .boot_pins(boot_pins),
        .otp_load(otp_load), .otp_sec_word(otp_sec_word),
        .all_threads_paused(all_threads_paused), .tx_data_i(tx_data_i),
        .tx_data_o(tx_data_o), .tx_clk_o(tx_clk_o), .rgmii_en_o(rgmii_en_o),
        .lp_div_active_o(lp_div_active_o), .core_clk_en_o(core_clk_en_o),
        .utmi_sel_o(utmi_sel_o), .ulpi_hw_en_o(ulpi_hw_en_o),
        .sec_ctl_o(sec_ctl_o), .ro_en_core_o(ro_en_core_o),
        .ro_en_periph_o(ro_en_periph_o), .ro_tick(ro_tick));
    core_model core (.clk(clk), .ps_req(ps_req), .ps_rsp(ps_rsp));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_total == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [7:0] num,
                       input logic [31:0] wd, input logic xe);
        logic er, ok;
        core.access(wr, num, RID_TYPE_PS, wd, rd, er, ok);
        `CHK("ack", 1'b1, ok);
        `CHK("err", xe, er);
    endtask

    task automatic do_reset();
        @(posedge clk) srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
    endtask

    always @(posedge clk) begin
        cyc++;
        tx_data_i <= tx_data_i + 5'h01;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_ctl();
        logic er, ok;
        acc(0, REG_TILE_CONTROL, 0, 0);
        `CHK("ctl rst", CTL_RST, rd);
        acc(0, REG_RO_CONTROL, 0, 0);
        `CHK("roc rst", 32'h0, rd);
        `CHK("core en rst", 1'b1, core_clk_en_o);
        acc(1, REG_TILE_CONTROL, 32'hffff_ffcf, 0);
        acc(0, REG_TILE_CONTROL, 0, 0);
        `CHK("ctl mask", CTL_WR_MASK & 32'hffff_ffcf, rd);
        `CHK("rgmii", 1'b1, rgmii_en_o);
        `CHK("utmi", 1'b1, utmi_sel_o);
        `CHK("ulpi hw", 1'b1, ulpi_hw_en_o);
        acc(1, REG_TILE_CONTROL, 32'h0000_0002, 0);
        `CHK("ulpi sel", 1'b0, utmi_sel_o);
        `CHK("rgmii off", 1'b0, rgmii_en_o);
        core.access(0, REG_TILE_CONTROL, 8'h0d, 0, rd, er, ok);
        `CHK("bad ack", 1'b1, ok);
        `CHK("bad kind", 1'b1, er);
        acc(0, 8'h04, 0, 1);
        `CHK("unmapped", 32'h0, rd);
    endtask

    task automatic t_boot();
        @(posedge clk) boot_pins <= '{8'ha5, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2};
        acc(1, REG_BOOT_STATUS, 32'hffff_ffff, 0);
        acc(0, REG_BOOT_STATUS, 0, 0);
        `CHK("boot", 32'h00a5_0116, rd);
        @(posedge clk) boot_pins <= '{8'h5a, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1};
        acc(0, REG_BOOT_STATUS, 0, 0);
        `CHK("boot2", 32'h005a_0029, rd);
    endtask

    task automatic t_security();
        @(posedge clk) otp_sec_word <= 32'h7fff_ffff;
        otp_load <= 1'b1;
        @(posedge clk) otp_load <= 1'b0;
        acc(0, REG_SECURITY, 0, 0);
        `CHK("sec otp", 32'h0000_5fb1, rd);
        `CHK("sec out", 10'h3ff, sec_ctl_o);
        acc(1, REG_SECURITY, 32'h8000_0010, 0);
        `CHK("sec jtag", 10'h002, sec_ctl_o);
        acc(1, REG_SECURITY, 32'h0000_5fb1, 0);
        acc(0, REG_SECURITY, 0, 0);
        `CHK("sec lock", 32'h8000_0010, rd);
        do_reset();
        acc(0, REG_SECURITY, 0, 0);
        `CHK("sec rst", SEC_RST, rd);
        acc(1, REG_SECURITY, 32'h0000_0001, 0);
        `CHK("sec reopen", 10'h001, sec_ctl_o);
    endtask

    task automatic t_tx(input logic [7:0] dly, input logic [8:0] div);
        int hi, rise;
        logic last;
        hi = 0;
        rise = 0;
        acc(1, REG_TILE_CONTROL, {6'h0, dly, div, 9'h0}, 0);
        repeat (24) @(posedge clk);
        last = tx_clk_o;
        repeat (4 * (div + 1)) begin
            @(negedge clk);
            `CHK("txd", 5'(tx_data_i - dly - 1), tx_data_o);
            hi += tx_clk_o;
            rise += (tx_clk_o && !last);
            last = tx_clk_o;
        end
        `CHK("txc high", 4 * ((div >> 1) + 1), hi);
        `CHK("txc rise", 4, rise);
    endtask

    task automatic t_freeze();
        logic [4:0] held;
        @(posedge clk) ce <= 1'b0;
        @(negedge clk) held = tx_data_o;
        repeat (3) @(negedge clk);
        `CHK("ce freeze", held, tx_data_o);
        @(posedge clk) ce <= 1'b1;
    endtask

    task automatic t_lowpower();
        int n;
        n = 0;
        acc(1, REG_TILE_CONTROL, 32'h0000_0010, 0);
        `CHK("static act", 1'b1, lp_div_active_o);
        repeat (16) @(negedge clk) n += core_clk_en_o;
        `CHK("div pulses", 4, n);
        acc(1, REG_TILE_CONTROL, 32'h0000_0030, 0);
        `CHK("dyn busy", 1'b0, lp_div_active_o);
        repeat (3) @(negedge clk) `CHK("dyn run", 1'b1, core_clk_en_o);
        @(posedge clk) all_threads_paused <= 1'b1;
        @(negedge clk) `CHK("dyn pause", 1'b1, lp_div_active_o);
        @(posedge clk) all_threads_paused <= 1'b0;
    endtask

    task automatic t_ring();
        for (int i = 0; i < RO_COUNT; i++) begin
            acc(0, REG_RO_VALUE0 + 8'(i), 0, 0);
            base[i] = rd;
        end
        acc(1, REG_RO_CONTROL, 32'hffff_fffe, 0);
        `CHK("ro core", 1'b1, ro_en_core_o);
        `CHK("ro per", 1'b0, ro_en_periph_o);
        @(posedge clk) ro_tick <= 4'hf;
        repeat (5) @(posedge clk);
        ro_tick <= 4'h0;
        acc(0, REG_RO_CONTROL, 0, 0);
        `CHK("roc rd", 32'h2, rd);
        acc(1, REG_RO_CONTROL, 0, 0);
        repeat (10) @(posedge clk);
        do_reset();
        for (int i = 0; i < RO_COUNT; i++) begin
            acc(0, REG_RO_VALUE0 + 8'(i), 0, 0);
            base[i][15:0] = base[i][15:0] + ((i < 2) ? 16'h0005 : 16'h0000);
            `CHK("ro cnt", {16'h0, base[i][15:0]}, rd);
        end
    endtask

    initial begin
        {err_total, checks_done, cyc} = '0;
        {srst, ce, otp_load, all_threads_paused} = 4'b1100;
        {boot_pins, otp_sec_word, tx_data_i, ro_tick} = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset_and_ctl();
        t_boot();
        t_security();
        t_tx(8'h02, 9'h003);
        t_tx(8'h00, 9'h004);
        t_freeze();
        t_lowpower();
        t_ring();
        final_report();
    end
endmodule
